/* File: hw/stcb_defines.vh */
// Constants for the switch threshold configuration bank.
// Included by every design file of the bank; definitions only.
`ifndef STCB_DEFINES_VH
`define STCB_DEFINES_VH

// Register offsets
`define STCB_ADDR_W 6
`define STCB_OFS_PAIR_0_1 6'h29
`define STCB_OFS_PAIR_2_3 6'h2A
`define STCB_OFS_PAIR_4_5 6'h2B
`define STCB_OFS_PAIR_6_7 6'h2C
`define STCB_OFS_PAIR_8_9 6'h2D
`define STCB_OFS_SELECT_LOW 6'h2E
`define STCB_OFS_FIRST 6'h29
`define STCB_PAIR_COUNT 5

// Widths and field layout
`define STCB_REG_W 24
`define STCB_LIMIT_W 10
`define STCB_PAIR_W 20
`define STCB_EVEN_LSB 0
`define STCB_EVEN_MSB 9
`define STCB_ODD_LSB 10
`define STCB_ODD_MSB 19
`define STCB_RSVD_LSB 20
`define STCB_RSVD_MSB 23
`define STCB_RSVD_W 4
`define STCB_SEL_W 3
`define STCB_INPUTS 8
`define STCB_LIMITS 10

// Reset values
`define STCB_PAIR_RESET 20'h00000
`define STCB_SELECT_RESET 24'h000000
`define STCB_RSVD_VALUE 4'h0

`endif

/* File: hw/stcb_limit_pair.v */
// One threshold pair register: even limit low, odd limit high.
// Assumes the caller decodes the address and gives a one-cycle write strobe.
`timescale 1ns/1ps
`include "stcb_defines.vh"

module stcb_limit_pair #(
    parameter LIMIT_W = `STCB_LIMIT_W
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Write side
    input wire wr_en,
    input wire [2*LIMIT_W-1:0] wr_data,
    // Stored limits
    output reg [LIMIT_W-1:0] even_limit,
    output reg [LIMIT_W-1:0] odd_limit
);

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            even_limit <= {LIMIT_W{1'b0}};
            odd_limit <= {LIMIT_W{1'b0}};
        end
        else if (wr_en)
        begin
            // Bit order kept as written, lowest bit least weight
            even_limit <= wr_data[LIMIT_W-1:0];
            odd_limit <= wr_data[2*LIMIT_W-1:LIMIT_W];
        end
    end

endmodule // stcb_limit_pair

/* File: hw/stcb_limit_mux.v */
// Picks one of stored limits 0 to 7 of the ten for one input.
// Assumes limits packed flat, limit n at bits n*LIMIT_W upward.
`timescale 1ns/1ps
`include "stcb_defines.vh"

module stcb_limit_mux #(
    parameter LIMIT_W = `STCB_LIMIT_W,
    parameter LIMITS = `STCB_LIMITS,
    parameter SEL_W = `STCB_SEL_W
) (
    // Inputs
    input wire [LIMITS*LIMIT_W-1:0] limits,
    input wire [SEL_W-1:0] select,
    // Chosen limit
    output wire [LIMIT_W-1:0] chosen
);

    // Selector reaches only limits 0..7; 8 and 9 are not selectable here
    assign chosen = limits[select*LIMIT_W +: LIMIT_W];

endmodule // stcb_limit_mux

/* File: hw/stcb_bank.v */
// Threshold configuration bank: five limit pair registers and one
// per-input limit selector register, with the chosen limit per input.
// Assumes a serial front end that turns host frames into one-cycle
// read and write strobes with a register offset, synchronous to clk.
//
// Notes on behaviour
// - Each pair register holds two 10-bit limits, even in 9:0, odd in 19:10.
// - Lowest bit of each limit field has least weight, highest bit most.
// - Bits 23:20 of pair registers read zero; limit fields are read-write.
// - Limits 0 to 9 sit pairwise in registers at offsets 29h through 2Dh.
// - Pair registers at 29h to 2Bh clear to zero on reset.
// - Pair registers at 2Ch and 2Dh also clear to zero on reset.
// - Selector register 2Eh holds eight 3-bit fields, input 0 lowest.
// - Selector value n makes that input compare against limit n.
`timescale 1ns/1ps
`include "stcb_defines.vh"

module stcb_bank #(
    parameter LIMIT_W = `STCB_LIMIT_W,
    parameter SEL_W = `STCB_SEL_W,
    parameter INPUTS = `STCB_INPUTS
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register access
    input wire [`STCB_ADDR_W-1:0] reg_addr,
    input wire reg_wr_en,
    input wire [`STCB_REG_W-1:0] reg_wr_data,
    input wire reg_rd_en,
    output reg [`STCB_REG_W-1:0] reg_rd_data,
    output reg reg_rd_valid,
    output reg reg_addr_error,
    // Stored limits, limit n at bits n*10 upward
    output reg [`STCB_LIMITS*LIMIT_W-1:0] limit_values,
    // Selector fields, input n at bits n*3 upward
    output reg [INPUTS*SEL_W-1:0] limit_selects,
    // Limit chosen for each input, input n at bits n*10 upward
    output reg [INPUTS*LIMIT_W-1:0] selected_limits
);

    localparam PAIRS = `STCB_PAIR_COUNT;

    wire [PAIRS*2*LIMIT_W-1:0] pair_values;
    wire [PAIRS-1:0] pair_hit;
    wire select_hit;
    wire addr_mapped;
    wire [INPUTS*LIMIT_W-1:0] next_selected_limits;
    reg [INPUTS*SEL_W-1:0] select_reg;
    reg [`STCB_REG_W-1:0] next_rd_data;
    integer k;

    // Decode
    genvar p;
    generate
        for (p = 0; p < PAIRS; p = p + 1)
        begin : g_pair
            assign pair_hit[p] = (reg_addr == (`STCB_OFS_FIRST + p));
            stcb_limit_pair #(
                .LIMIT_W(LIMIT_W)
            ) u_pair (
                .clk(clk),
                .reset_n(reset_n),
                .wr_en(reg_wr_en & pair_hit[p]),
                // Reserved bits 23:20 of the write are dropped
                .wr_data(reg_wr_data[`STCB_ODD_MSB:`STCB_EVEN_LSB]),
                .even_limit(pair_values[p*2*LIMIT_W +: LIMIT_W]),
                .odd_limit(pair_values[p*2*LIMIT_W+LIMIT_W +: LIMIT_W])
            );
        end
    endgenerate

    assign select_hit = (reg_addr == `STCB_OFS_SELECT_LOW);
    assign addr_mapped = (|pair_hit) | select_hit;

    // Selector register
    always @(posedge clk)
    begin
        if (!reset_n)
            select_reg <= `STCB_SELECT_RESET;
        else if (reg_wr_en && select_hit)
            select_reg <= reg_wr_data[INPUTS*SEL_W-1:0];
    end

    // Read multiplexer; reserved bits and unmapped offsets give zero
    always @*
    begin
        next_rd_data = {`STCB_REG_W{1'b0}};
        for (k = 0; k < PAIRS; k = k + 1)
        begin
            if (pair_hit[k])
                next_rd_data = {`STCB_RSVD_VALUE, pair_values[k*2*LIMIT_W +: 2*LIMIT_W]};
        end
        if (select_hit)
            next_rd_data = select_reg;
    end

    // Per-input limit choice
    genvar i;
    generate
        for (i = 0; i < INPUTS; i = i + 1)
        begin : g_input
            stcb_limit_mux #(
                .LIMIT_W(LIMIT_W),
                .LIMITS(`STCB_LIMITS),
                .SEL_W(SEL_W)
            ) u_mux (
                .limits(pair_values),
                .select(select_reg[i*SEL_W +: SEL_W]),
                .chosen(next_selected_limits[i*LIMIT_W +: LIMIT_W])
            );
        end
    endgenerate

    // Registered outputs; chosen limits trail a write by one cycle
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            reg_rd_data <= {`STCB_REG_W{1'b0}};
            reg_rd_valid <= 1'b0;
            reg_addr_error <= 1'b0;
            limit_values <= {(`STCB_LIMITS*LIMIT_W){1'b0}};
            limit_selects <= {(INPUTS*SEL_W){1'b0}};
            selected_limits <= {(INPUTS*LIMIT_W){1'b0}};
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
                reg_rd_data <= next_rd_data;
            // Flags any access to an offset outside the bank
            reg_addr_error <= (reg_rd_en | reg_wr_en) & ~addr_mapped;
            limit_values <= pair_values;
            limit_selects <= select_reg;
            selected_limits <= next_selected_limits;
        end
    end

endmodule // stcb_bank

/* File: verification/stcb_bank_props.sv */
// Assertions on the threshold bank ports.
// Bound to stcb_bank below; sees its ports only.
`timescale 1ns/1ps
module stcb_bank_props (
    // Watched ports
    input wire clk,
    input wire reset_n,
    input wire [5:0] reg_addr,
    input wire reg_wr_en,
    input wire [23:0] reg_wr_data,
    input wire reg_rd_en,
    input wire [23:0] reg_rd_data,
    input wire reg_rd_valid,
    input wire reg_addr_error,
    input wire [99:0] limit_values,
    input wire [23:0] limit_selects,
    input wire [79:0] selected_limits
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid) else $error("no valid");
    AST_RSVD: assert property (reg_rd_en && reg_addr != 6'h2E |=>
        reg_rd_data[23:20] == 4'h0) else $error("rsvd set");
    AST_PAIR: assert property (reg_wr_en && reg_addr == 6'h29 ##1 !reg_wr_en |=>
        limit_values[19:0] == $past(reg_wr_data[19:0], 2)) else $error("pair");
    AST_SEL: assert property (reg_wr_en && reg_addr == 6'h2E ##1 !reg_wr_en |=>
        limit_selects == $past(reg_wr_data, 2)) else $error("sel");
    AST_MUX0: assert property ($stable(limit_values) && $stable(limit_selects) |->
        selected_limits[9:0] == limit_values[limit_selects[2:0]*10 +: 10]) else $error("in0");
    AST_MUX7: assert property ($stable(limit_values) && $stable(limit_selects) |->
        selected_limits[79:70] == limit_values[limit_selects[23:21]*10 +: 10]) else $error("in7");
    AST_RST: assert property ($rose(reset_n) |-> limit_values == 100'h0
        && limit_selects == 24'h0) else $error("no clear");
    AST_BAD: assert property (reg_rd_en && reg_addr > 6'h2E |=> reg_addr_error)
        else $error("no error");
    cover property (reg_addr_error);
    cover property (reg_wr_en && reg_addr == 6'h2E);
    cover property (reg_rd_valid && reg_rd_data != 24'h0);
endmodule // stcb_bank_props
bind stcb_bank stcb_bank_props stcb_bank_props_i (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid),
    .reg_addr_error(reg_addr_error),
    .limit_values(limit_values),
    .limit_selects(limit_selects),
    .selected_limits(selected_limits)
);

/* File: verification/stcb_host.sv */
// Host model: one-cycle strobes on the bank register port.
// Drives on falling clk; the bank samples on rising clk.
`timescale 1ns/1ps
module stcb_host (
    // Clock and register port
    input wire clk,
    output reg [5:0] reg_addr = 6'h00,
    output reg reg_wr_en = 1'b0,
    output reg [23:0] reg_wr_data = 24'h000000,
    output reg reg_rd_en = 1'b0,
    input wire [23:0] reg_rd_data,
    input wire reg_rd_valid
);
    // Data inverted on release so a stale value never passes
    task x(input w, input [5:0] a, input [23:0] d, output [24:0] r);
        @(negedge clk);
        {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = {a, d, w, !w};
        @(negedge clk);
        {reg_wr_en, reg_rd_en, reg_wr_data, r} = {2'b00, ~d, reg_rd_valid, reg_rd_data};
    endtask
endmodule // stcb_host

/* File: verification/tb.sv */
// Bench for the threshold bank, driven through the host model.
// Assumes the checker binds itself to stcb_bank.
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0, reset_n = 1'b0;
    wire [5:0] reg_addr;
    wire reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_error;
    wire [23:0] reg_wr_data, reg_rd_data, limit_selects;
    wire [99:0] limit_values;
    wire [79:0] selected_limits;
    reg [24:0] rv;
    integer fail_count = 0, samples_checked = 0;
    reg [9:0] lim [0:9] = '{10'h001, 10'h200, 10'h002, 10'h100, 10'h004,
        10'h080, 10'h008, 10'h040, 10'h010, 10'h020};
    always #2.5 clk = ~clk;
    stcb_bank stcb_bank_i (
        .clk(clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid),
        .reg_addr_error(reg_addr_error),
        .limit_values(limit_values),
        .limit_selects(limit_selects),
        .selected_limits(selected_limits)
    );
    stcb_host stcb_host_i (
        .clk(clk),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid)
    );
    task chk(input string n, input [99:0] got, exp);
        samples_checked++;
        fail_count += (got !== exp);
        if (got !== exp)
            $display("[ERR] %s exp %h got %h", n, exp, got);
    endtask
    task rdc(input [5:0] a, input [23:0] exp);
        stcb_host_i.x(1'b0, a, 24'h000000, rv);
        chk("rdata", rv, {1'b1, exp});
    endtask
    task complete_run;
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task t_reset;
        stcb_host_i.x(1'b1, 6'h2F, 24'hFFFFFF, rv);
        chk("addr_error", reg_addr_error, 1'b1);
        for (int i = 40; i < 48; i++)
        begin
            rdc(6'(i), 24'h000000);
            chk("addr_error", reg_addr_error, (i < 41 || i > 46));
        end
    endtask
    // Reset after nonzero contents, so clearing is seen on live values
    task t_mid_reset;
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        chk("values", limit_values, 100'h0);
        chk("selects", limit_selects, 24'h000000);
        chk("chosen", selected_limits, 80'h0);
        for (int i = 41; i < 47; i++) rdc(6'(i), 24'h000000);
    endtask
    task t_limits;
        for (int p = 0; p < 5; p++)
        begin
            stcb_host_i.x(1'b1, 6'h29 + 6'(p), {4'hF, lim[2*p+1], lim[2*p]}, rv);
            chk("addr_error", reg_addr_error, 1'b0);
            rdc(6'h29 + 6'(p), {4'h0, lim[2*p+1], lim[2*p]});
            chk("limits", limit_values[20*p +: 20], {lim[2*p+1], lim[2*p]});
        end
        stcb_host_i.x(1'b1, 6'h2E, 24'h053977, rv);
        rdc(6'h2E, 24'h053977);
        chk("selects", limit_selects, 24'h053977);
        for (int i = 0; i < 8; i++)
            chk("chosen", selected_limits[10*i +: 10], lim[7-i]);
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        t_reset;
        t_limits;
        t_mid_reset;
        complete_run;
    end
endmodule // tb
